// ---- rtl/iptsr_pkg.sv ----
// constants for the interrupt priority, trap and flag register block
package iptsr_pkg;
  // ***********************************************
  // register map (word indices, one word each)
  // ***********************************************
  localparam int          ADDR_W          = 5;
  localparam logic [2:0]  IDX_CPU_STATUS  = 3'h0;
  localparam logic [2:0]  IDX_CORE_CTRL   = 3'h1;
  localparam logic [2:0]  IDX_TRAP_CTRL   = 3'h2;
  localparam logic [2:0]  IDX_VEC_EDGE    = 3'h3;
  localparam logic [2:0]  IDX_REQ_FLAGS0  = 3'h4;
  localparam int          IDX_LSB         = 2;
  localparam int          IDX_MSB         = 4;

  // ***********************************************
  // field positions
  // ***********************************************
  localparam int          PRIO_LOW_LSB    = 5;
  localparam int          PRIO_LOW_MSB    = 7;
  localparam int          PRIO_TOP_BIT    = 3;
  localparam int          NEST_OFF_BIT    = 15;
  localparam int          ACC_A_OVF_BIT   = 14;
  localparam int          ACC_B_OVF_BIT   = 13;
  localparam int          ACC_A_CAT_BIT   = 12;
  localparam int          ACC_B_CAT_BIT   = 11;
  localparam int          ACC_A_EN_BIT    = 10;
  localparam int          ACC_B_EN_BIT    = 9;
  localparam int          CAT_EN_BIT      = 8;
  localparam int          BAD_SHIFT_BIT   = 7;
  localparam int          DIV_ZERO_BIT    = 6;
  localparam int          DMA_FAULT_BIT   = 5;
  localparam int          MATH_BIT        = 4;
  localparam int          ADDR_TRAP_BIT   = 3;
  localparam int          STACK_TRAP_BIT  = 2;
  localparam int          OSC_FAIL_BIT    = 1;
  localparam int          ALT_VEC_BIT     = 15;
  localparam int          TEMP_BLOCK_BIT  = 14;
  localparam int          EXT_POL_MSB     = 4;
  localparam int          EXT_COUNT       = 5;

  // ***********************************************
  // writable masks and reset values
  // ***********************************************
  localparam logic [15:0] TRAP_CTRL_MASK  = 16'hfffe;
  localparam logic [15:0] VEC_EDGE_WMASK  = 16'h801f;
  localparam logic [15:0] REQ_FLAGS_MASK  = 16'h7fff;
  localparam logic [15:0] REG_RESET       = 16'h0000;
  localparam logic [3:0]  PRIO_RESET      = 4'h0;
  localparam logic [2:0]  PRIO_LOW_MAX    = 3'h7;
  localparam logic [31:0] READ_ZERO       = 32'h0000_0000;
endpackage

// ---- rtl/iptsr_regs.sv ----
// interrupt priority level, trap cause and request flag registers on Avalon-MM
//
// Operation
// - low three priority bits held in cpu status bits 7..5; 111 blocks user interrupts.
// - priority level is core control bit 3 over the low field; top one blocks users.
// - software writes to the low priority field ignored while nesting is off.
// - core control bit 3 reads one when level exceeds 7; software may only clear.
// - read/write nesting-off bit 15 of trap control stops pre-emption of a routine.
// - bits 14 and 13 latch overflow traps of accumulators A and B.
// - bits 12 and 11 latch catastrophic overflow traps of accumulators A and B.
// - overflow trap of A only with bit 10 set, of B only with bit 9.
// - catastrophic overflow traps only while the shared enable bit 8 is set.
// - bit 4 on any math trap; bit 7 for bad shift, bit 6 for divide by zero.
// - bit 5 of trap control latches a DMA controller error trap.
// - bits 3, 2, 1 latch address, stack, oscillator traps; bit 0 reads zero.
// - vector control bit 15 selects the alternate vector table.
// - read-only vector control bit 14 shows the temporary interrupt block.
// - external interrupts 4..0 trigger on falling edge when polarity bit is one.
// - request flag bit 13 latches a grouped analog conversion completion.
// - request flag bits 14 and 4 latch DMA channel 1 and 0 completion.
// - request flag bits 12 and 11 latch first UART transmit and receive.
// - request flag bits 10 and 9 latch first SPI event and fault.
// - request flag bits 8, 7, 3 latch timers 3, 2, 1.
// - request flag bits 6 and 5 latch compare 2 and capture 2.
// - flags are set by hardware or by a software one, and cleared only by software.
// - top priority bit cannot be set by software, so traps stay unmaskable.
//
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module iptsr_regs (
  input  wire logic        mclk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // core side
  input  wire logic        prioLoad,
  input  wire logic [3:0]  prioLoadLevel,
  input  wire logic        tempIrqBlock,
  input  wire logic        accAOvf,
  input  wire logic        accBOvf,
  input  wire logic        accACatastrophic,
  input  wire logic        accBCatastrophic,
  input  wire logic        badShift,
  input  wire logic        divideZero,
  input  wire logic        dmaFault,
  input  wire logic        addressFault,
  input  wire logic        stackFault,
  input  wire logic        osc_fail_trap_flag,
  // peripheral request events
  input  wire logic        dmaCh1Done,
  input  wire logic        adcGroupDone,
  input  wire logic        uart1Tx,
  input  wire logic        uart1Rx,
  input  wire logic        spi1Event,
  input  wire logic        spi1Fault,
  input  wire logic        timer3Evt,
  input  wire logic        timer2Evt,
  input  wire logic        compare2Evt,
  input  wire logic        capture2Evt,
  input  wire logic        dmaCh0Done,
  input  wire logic        timer1Evt,
  input  wire logic        compare1Evt,
  input  wire logic        capture1Evt,
  input  wire logic [4:0]  extIrqPin,
  // status toward arbitration and vectoring
  output logic      [3:0]  cpuPrioLevel,
  output logic             userIrqBlocked,
  output logic             nestingOff,
  output logic             altVectorSel,
  output logic             trapReq,
  output logic      [4:0]  extEdgeEvt,
  output logic      [15:0] requestFlags0
);

  // ***********************************************
  // helpers
  // ***********************************************
  // byte-lane merge of a 16-bit register, restricted to its writable bits
  function automatic logic [15:0] laneMerge(input logic [15:0] oldVal,
                                            input logic [31:0] wdata,
                                            input logic [3:0]  be,
                                            input logic [15:0] wmask);
    logic [15:0] merged;
    merged = oldVal;
    if (be[0]) begin
      merged[7:0] = wdata[7:0];
    end
    if (be[1]) begin
      merged[15:8] = wdata[15:8];
    end
    return (merged & wmask) | (oldVal & ~wmask);
  endfunction

  // ***********************************************
  // state
  // ***********************************************
  logic [2:0]  prioLow;
  logic        prioTop;
  logic [15:0] trapCtrl;
  logic        altVec;
  logic        tempBlock;
  logic [4:0]  extPol;
  logic [15:0] reqFlags;
  logic [4:0]  extPrev;

  // ***********************************************
  // bus decode
  // ***********************************************
  wire logic [2:0] regIdx     = avs_address[iptsr_pkg::IDX_MSB:iptsr_pkg::IDX_LSB];
  // an access completes on the edge where waitrequest is sampled low
  wire logic       accessDone = (avs_read | avs_write) & ~avs_waitrequest;
  wire logic       wrDone     = avs_write & ~avs_waitrequest;
  wire logic       wrStatus   = wrDone & (regIdx == iptsr_pkg::IDX_CPU_STATUS);
  wire logic       wrCore     = wrDone & (regIdx == iptsr_pkg::IDX_CORE_CTRL);
  wire logic       wrTrap     = wrDone & (regIdx == iptsr_pkg::IDX_TRAP_CTRL);
  wire logic       wrVec      = wrDone & (regIdx == iptsr_pkg::IDX_VEC_EDGE);
  wire logic       wrFlags    = wrDone & (regIdx == iptsr_pkg::IDX_REQ_FLAGS0);

  // ***********************************************
  // read views
  // ***********************************************
  wire logic [15:0] statusView = {8'h00, prioLow, 5'h00};
  wire logic [15:0] coreView   = {12'h000, prioTop, 3'h0};
  wire logic [15:0] vecView    = {altVec, tempBlock, 9'h000, extPol};
  wire logic [15:0] readView   =
    (regIdx == iptsr_pkg::IDX_CPU_STATUS) ? statusView :
    (regIdx == iptsr_pkg::IDX_CORE_CTRL)  ? coreView :
    (regIdx == iptsr_pkg::IDX_TRAP_CTRL)  ? trapCtrl :
    (regIdx == iptsr_pkg::IDX_VEC_EDGE)   ? vecView :
    (regIdx == iptsr_pkg::IDX_REQ_FLAGS0) ? reqFlags : 16'h0000;

  // ***********************************************
  // priority level
  // ***********************************************
  // writable masks follow the field constants rather than hand-written bit patterns
  wire logic [15:0] statusWMask  = 16'(iptsr_pkg::PRIO_LOW_MAX) << iptsr_pkg::PRIO_LOW_LSB;
  wire logic [15:0] coreWMask    = 16'h0001 << iptsr_pkg::PRIO_TOP_BIT;
  wire logic [15:0] statusMerged = laneMerge(statusView, avs_writedata, avs_byteenable, statusWMask);
  wire logic [15:0] coreMerged   = laneMerge(coreView, avs_writedata, avs_byteenable, coreWMask);
  // core loads win: they track trap and interrupt entry and return
  wire logic [2:0]  next_prioLow =
    prioLoad ? prioLoadLevel[2:0] :
    (wrStatus & ~trapCtrl[iptsr_pkg::NEST_OFF_BIT]) ?
      statusMerged[iptsr_pkg::PRIO_LOW_MSB:iptsr_pkg::PRIO_LOW_LSB] : prioLow;
  // software can only clear the top bit, never raise it
  wire logic        next_prioTop =
    prioLoad ? prioLoadLevel[3] :
    wrCore ? (prioTop & coreMerged[iptsr_pkg::PRIO_TOP_BIT]) : prioTop;
  wire logic        next_blocked = next_prioTop | (next_prioLow == iptsr_pkg::PRIO_LOW_MAX);

  always_ff @(posedge mclk) begin
    if (rst) begin
      prioLow        <= iptsr_pkg::PRIO_RESET[2:0];
      prioTop        <= iptsr_pkg::PRIO_RESET[3];
      cpuPrioLevel   <= iptsr_pkg::PRIO_RESET;
      userIrqBlocked <= 1'b0;
    end else begin
      prioLow        <= next_prioLow;
      prioTop        <= next_prioTop;
      cpuPrioLevel   <= {next_prioTop, next_prioLow};
      userIrqBlocked <= next_blocked;
    end
  end

  // ***********************************************
  // trap control and cause flags
  // ***********************************************
  wire logic ovfATrap = accAOvf & trapCtrl[iptsr_pkg::ACC_A_EN_BIT];
  wire logic ovfBTrap = accBOvf & trapCtrl[iptsr_pkg::ACC_B_EN_BIT];
  wire logic catATrap = accACatastrophic & trapCtrl[iptsr_pkg::CAT_EN_BIT];
  wire logic catBTrap = accBCatastrophic & trapCtrl[iptsr_pkg::CAT_EN_BIT];
  // every enabled accumulator trap is a math trap, so it marks the summary bit too
  wire logic mathTrap = badShift | divideZero | ovfATrap | ovfBTrap | catATrap | catBTrap;

  logic [15:0] trapSet;
  always_comb begin
    trapSet                               = 16'h0000;
    trapSet[iptsr_pkg::ACC_A_OVF_BIT]     = ovfATrap;
    trapSet[iptsr_pkg::ACC_B_OVF_BIT]     = ovfBTrap;
    trapSet[iptsr_pkg::ACC_A_CAT_BIT]     = catATrap;
    trapSet[iptsr_pkg::ACC_B_CAT_BIT]     = catBTrap;
    trapSet[iptsr_pkg::BAD_SHIFT_BIT]     = badShift;
    trapSet[iptsr_pkg::DIV_ZERO_BIT]      = divideZero;
    trapSet[iptsr_pkg::MATH_BIT]          = mathTrap;
    trapSet[iptsr_pkg::DMA_FAULT_BIT]     = dmaFault;
    trapSet[iptsr_pkg::ADDR_TRAP_BIT]     = addressFault;
    trapSet[iptsr_pkg::STACK_TRAP_BIT]    = stackFault;
    trapSet[iptsr_pkg::OSC_FAIL_BIT]      = osc_fail_trap_flag;
  end

  wire logic [15:0] trapBase =
    wrTrap ? laneMerge(trapCtrl, avs_writedata, avs_byteenable, iptsr_pkg::TRAP_CTRL_MASK) : trapCtrl;
  // a trap arriving with a clearing write still lands; bit 0 stays zero
  wire logic [15:0] next_trapCtrl = (trapBase | trapSet) & iptsr_pkg::TRAP_CTRL_MASK;

  always_ff @(posedge mclk) begin
    if (rst) begin
      trapCtrl   <= iptsr_pkg::REG_RESET;
      nestingOff <= 1'b0;
      trapReq    <= 1'b0;
    end else begin
      trapCtrl   <= next_trapCtrl;
      nestingOff <= next_trapCtrl[iptsr_pkg::NEST_OFF_BIT];
      trapReq    <= |trapSet;
    end
  end

  // ***********************************************
  // vector select, temporary block, edge polarity
  // ***********************************************
  wire logic [15:0] vecMerged =
    laneMerge(vecView, avs_writedata, avs_byteenable, iptsr_pkg::VEC_EDGE_WMASK);
  wire logic        next_altVec = wrVec ? vecMerged[iptsr_pkg::ALT_VEC_BIT] : altVec;
  wire logic [4:0]  next_extPol = wrVec ? vecMerged[iptsr_pkg::EXT_POL_MSB:0] : extPol;

  always_ff @(posedge mclk) begin
    if (rst) begin
      altVec       <= 1'b0;
      altVectorSel <= 1'b0;
      tempBlock    <= 1'b0;
      extPol       <= 5'h00;
    end else begin
      altVec       <= next_altVec;
      altVectorSel <= next_altVec;
      tempBlock    <= tempIrqBlock;
      extPol       <= next_extPol;
    end
  end

  // ***********************************************
  // external edge detection
  // ***********************************************
  // a polarity change alone never looks like an edge, since edges come from
  // the pin history only; software need not clear the flag after changing polarity
  wire logic [4:0] riseEdge = extIrqPin & ~extPrev;
  wire logic [4:0] fallEdge = ~extIrqPin & extPrev;
  wire logic [4:0] extHit   = (extPol & fallEdge) | (~extPol & riseEdge);

  always_ff @(posedge mclk) begin
    if (rst) begin
      extPrev    <= 5'h00;
      extEdgeEvt <= 5'h00;
    end else begin
      extPrev    <= extIrqPin;
      extEdgeEvt <= extHit;
    end
  end

  // ***********************************************
  // request flag register 0
  // ***********************************************
  wire logic [15:0] flagSet = {1'b0,
                               dmaCh1Done,
                               adcGroupDone,
                               uart1Tx, uart1Rx,
                               spi1Event, spi1Fault,
                               timer3Evt, timer2Evt,
                               compare2Evt, capture2Evt,
                               dmaCh0Done,
                               timer1Evt,
                               compare1Evt, capture1Evt,
                               extHit[0]};
  wire logic [15:0] flagBase =
    wrFlags ? laneMerge(reqFlags, avs_writedata, avs_byteenable, iptsr_pkg::REQ_FLAGS_MASK) : reqFlags;
  // hardware only ever sets; a clear needs a software zero, and a set wins
  wire logic [15:0] next_reqFlags = (flagBase | flagSet) & iptsr_pkg::REQ_FLAGS_MASK;

  always_ff @(posedge mclk) begin
    if (rst) begin
      reqFlags      <= iptsr_pkg::REG_RESET;
      requestFlags0 <= iptsr_pkg::REG_RESET;
    end else begin
      reqFlags      <= next_reqFlags;
      requestFlags0 <= next_reqFlags;
    end
  end

  // ***********************************************
  // Avalon handshake: one wait state per access
  // ***********************************************
  // waitrequest rests high; it drops for one cycle after a request is seen,
  // which keeps every access a fixed two edges long
  always_ff @(posedge mclk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= iptsr_pkg::READ_ZERO;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (avs_read & avs_waitrequest) begin
        avs_readdata <= {16'h0000, readView};
      end else if (accessDone) begin
        avs_readdata <= iptsr_pkg::READ_ZERO;
      end
    end
  end

endmodule
`default_nettype wire

// ---- tb/iptsr_regs_sva.sv ----
// assertion checker for the interrupt priority, trap and flag registers
`timescale 1ns/1ps
`default_nettype none
module iptsr_regs_sva (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        prioLoad,
  input wire logic [3:0]  prioLoadLevel,
  input wire logic        addressFault,
  input wire logic        stackFault,
  input wire logic        osc_fail_trap_flag,
  input wire logic        timer1Evt,
  input wire logic [3:0]  cpuPrioLevel,
  input wire logic        userIrqBlocked,
  input wire logic        nestingOff,
  input wire logic        trapReq,
  input wire logic [4:0]  extEdgeEvt,
  input wire logic [15:0] requestFlags0
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  wire wrDone = avs_write && !avs_waitrequest;
  wire srWrite = wrDone && (avs_address[4:2] == iptsr_pkg::IDX_CPU_STATUS);
  wire rfWrite = wrDone && (avs_address[4:2] == iptsr_pkg::IDX_REQ_FLAGS0);
  // ****************
  // bus handshake
  // ****************
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_ack; ##1 !avs_waitrequest ##1 avs_waitrequest; endsequence
  property p_ack; s_req |-> s_ack; endproperty
  a_ack: assert property (p_ack) else $error("bus access not answered in one cycle");
  property p_rd_idle; $rose(avs_waitrequest) |-> avs_readdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared after access");
  // ****************
  // priority and flags
  // ****************
  property p_blocked; userIrqBlocked == (cpuPrioLevel[3] || cpuPrioLevel[2:0] == 3'h7); endproperty
  a_blocked: assert property (p_blocked) else $error("user block wrong for level");
  property p_load; prioLoad |=> cpuPrioLevel == $past(prioLoadLevel); endproperty
  a_load: assert property (p_load) else $error("priority load not taken");
  property p_top_set; !cpuPrioLevel[3] && !prioLoad |=> !cpuPrioLevel[3]; endproperty
  a_top_set: assert property (p_top_set) else $error("top priority bit set by software");
  property p_nest_ro; nestingOff && !prioLoad && srWrite |=> $stable(cpuPrioLevel[2:0]); endproperty
  a_nest_ro: assert property (p_nest_ro) else $error("low priority changed while nesting off");
  property p_hold; !$past(rst) && |($past(requestFlags0) & ~requestFlags0) |-> $past(rfWrite); endproperty
  a_hold: assert property (p_hold) else $error("request flag cleared without write");
  property p_timer1; timer1Evt |=> requestFlags0[3]; endproperty
  a_timer1: assert property (p_timer1) else $error("timer1 flag not set");
  property p_trap; addressFault || stackFault || osc_fail_trap_flag |=> trapReq; endproperty
  a_trap: assert property (p_trap) else $error("trap request missing");
  property p_ext; extEdgeEvt[0] |-> requestFlags0[0]; endproperty
  a_ext: assert property (p_ext) else $error("ext0 edge without flag");
endmodule
bind iptsr_regs iptsr_regs_sva u_sva (.mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .prioLoad, .prioLoadLevel, .addressFault, .stackFault, .osc_fail_trap_flag, .timer1Evt,
  .cpuPrioLevel, .userIrqBlocked, .nestingOff, .trapReq, .extEdgeEvt, .requestFlags0);
`default_nettype wire

// ---- tb/iptsr_regs_tb_top.sv ----
// self-checking bench for the interrupt priority, trap and flag registers
`timescale 1ns/1ps
`default_nettype none
module iptsr_regs_tb_top;
  localparam logic [4:0] A_SR = {iptsr_pkg::IDX_CPU_STATUS, 2'b00};
  localparam logic [4:0] A_CC = {iptsr_pkg::IDX_CORE_CTRL, 2'b00};
  localparam logic [4:0] A_TC = {iptsr_pkg::IDX_TRAP_CTRL, 2'b00};
  localparam logic [4:0] A_VE = {iptsr_pkg::IDX_VEC_EDGE, 2'b00};
  localparam logic [4:0] A_RF = {iptsr_pkg::IDX_REQ_FLAGS0, 2'b00};
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        prioLoad = 1'b0;
  logic [3:0]  prioLoadLevel = 4'h0;
  logic        tempIrqBlock = 1'b0;
  logic [4:0]  extIrqPin = 5'h00;
  logic [23:0] fire = 24'h0;
  logic [23:0] evt;
  logic [3:0]  cpuPrioLevel;
  logic        userIrqBlocked, nestingOff, altVectorSel, trapReq;
  logic [4:0]  extEdgeEvt;
  logic [15:0] requestFlags0, rd, expF;
  int          n_fail = 0;
  int          tests_run = 0;
  always #25 mclk = ~mclk;
  iptsr_src_model u_src (.mclk, .rst, .fire, .evt);
  iptsr_regs u_dut (.mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'h3), .avs_readdata, .avs_waitrequest, .prioLoad, .prioLoadLevel, .tempIrqBlock,
    .accAOvf(evt[0]), .accBOvf(evt[1]), .accACatastrophic(evt[2]), .accBCatastrophic(evt[3]),
    .badShift(evt[4]), .divideZero(evt[5]), .dmaFault(evt[6]), .addressFault(evt[7]),
    .stackFault(evt[8]), .osc_fail_trap_flag(evt[9]), .dmaCh1Done(evt[10]), .adcGroupDone(evt[11]),
    .uart1Tx(evt[12]), .uart1Rx(evt[13]), .spi1Event(evt[14]), .spi1Fault(evt[15]),
    .timer3Evt(evt[16]), .timer2Evt(evt[17]), .compare2Evt(evt[18]), .capture2Evt(evt[19]),
    .dmaCh0Done(evt[20]), .timer1Evt(evt[21]), .compare1Evt(evt[22]), .capture1Evt(evt[23]),
    .extIrqPin, .cpuPrioLevel, .userIrqBlocked, .nestingOff, .altVectorSel, .trapReq, .extEdgeEvt,
    .requestFlags0);
  // ****************
  // shared tasks
  // ****************
  task automatic conclude;
    if (n_fail == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {16'h0, d};
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 16);
    rd = avs_readdata[15:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      n_fail++;
      conclude();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input string what, input logic [4:0] a, input logic [15:0] exp);
    xfer(1'b0, a, 16'h0);
    chk(what, {16'h0, rd}, {16'h0, exp});
  endtask
  // strobe lands one cycle later through the source model, flag one cycle after that
  task automatic pulse(input logic [23:0] v);
    @(posedge mclk);
    fire <= v;
    @(posedge mclk);
    fire <= 24'h0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic pin_step(input logic [4:0] v, input logic [4:0] exp);
    @(posedge mclk);
    extIrqPin <= v;
    @(posedge mclk);
    #1 chk("edge pulse", {27'h0, extEdgeEvt}, {27'h0, exp});
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset;
    logic [4:0] addrs [6] = '{A_SR, A_CC, A_TC, A_VE, A_RF, 5'h14};
    foreach (addrs[i]) rdc("reset or unmapped", addrs[i], 16'h0000);
    chk("level out", {28'h0, cpuPrioLevel}, 32'h0);
  endtask
  task automatic t_prio;
    wr(A_SR, 16'h00e0);
    rdc("low prio", A_SR, 16'h00e0);
    chk("blocked at 7", userIrqBlocked, 1'b1);
    wr(A_SR, 16'h00c0);
    @(posedge mclk);
    chk("open at 6", userIrqBlocked, 1'b0);
    @(posedge mclk);
    prioLoad <= 1'b1;
    prioLoadLevel <= 4'h9;
    @(posedge mclk);
    prioLoad <= 1'b0;
    rdc("top prio", A_CC, 16'h0008);
    rdc("low after load", A_SR, 16'h0020);
    chk("blocked by top", userIrqBlocked, 1'b1);
    wr(A_CC, 16'h0000);
    rdc("top cleared", A_CC, 16'h0000);
    wr(A_CC, 16'h0008);
    rdc("top not set", A_CC, 16'h0000);
    wr(A_TC, 16'h8000);
    @(posedge mclk);
    chk("nesting out", nestingOff, 1'b1);
    wr(A_SR, 16'h00e0);
    rdc("low prio frozen", A_SR, 16'h0020);
    wr(A_TC, 16'h0000);
  endtask
  task automatic t_traps;
    pulse(24'h00000f);
    rdc("gated traps", A_TC, 16'h0000);
    wr(A_TC, 16'h0700);
    pulse(24'h00000f);
    rdc("ovf traps", A_TC, 16'h7f10);
    pulse(24'h0003f0);
    rdc("other traps", A_TC, 16'h7ffe);
    rdc("traps held", A_TC, 16'h7ffe);
    wr(A_TC, 16'h0201);
    rdc("cleared bit0 zero", A_TC, 16'h0200);
    pulse(24'h000003);
    rdc("acc b only", A_TC, 16'h2210);
    wr(A_TC, 16'h0000);
  endtask
  task automatic t_flags;
    expF = 16'h0000;
    for (int i = 10; i < 24; i++) begin
      pulse(24'h1 << i);
      expF[24 - i] = 1'b1;
      rdc("request flag", A_RF, expF);
    end
    chk("flags out", {16'h0, requestFlags0}, {16'h0, expF});
    wr(A_RF, 16'h0000);
    rdc("flags cleared", A_RF, 16'h0000);
    wr(A_RF, 16'hffff);
    rdc("flags set by write", A_RF, 16'h7fff);
    wr(A_RF, 16'h0000);
  endtask
  task automatic t_edges;
    wr(A_VE, 16'hffff);
    rdc("vector reg", A_VE, 16'h801f);
    chk("alt out", altVectorSel, 1'b1);
    @(posedge mclk);
    tempIrqBlock <= 1'b1;
    rdc("temp block", A_VE, 16'hc01f);
    @(posedge mclk);
    tempIrqBlock <= 1'b0;
    pin_step(5'h1f, 5'h00);
    pin_step(5'h00, 5'h1f);
    rdc("ext0 flag", A_RF, 16'h0001);
    wr(A_VE, 16'h0000);
    pin_step(5'h1f, 5'h1f);
    pin_step(5'h00, 5'h00);
    wr(A_RF, 16'h0000);
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_prio();
    t_traps();
    t_flags();
    t_edges();
    conclude();
  end
endmodule
`default_nettype wire

// ---- tb/iptsr_src_model.sv ----
// trap and peripheral event sources facing the register block
`timescale 1ns/1ps
`default_nettype none
module iptsr_src_model (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [23:0] fire,
  output logic      [23:0] evt
);
  // single-cycle strobes; the latched flag, not the strobe, carries the state
  always_ff @(posedge mclk) begin
    evt <= rst ? 24'h0 : fire;
  end
endmodule
`default_nettype wire
